// >>> rtl/pmrs_sequencer.sv
// Power-on and brownout reset sequencer with mode-based unit enables.
// Assumes power_on_pin and brownout inputs are asynchronous to core_clk,
// and that status reads arrive as single-cycle strobes on core_clk.
//
// Behaviour
// - With power-on low, stay in power down with all regulators off.
// - A rising power-on turns on digital regulators and starts reset.
// - A brownout on the digital supply starts a reset.
// - Between brownout and functional thresholds hold the line low.
// - On supply recovery pulse the line high, then hold full reset.
// - At reset exit preset every status register to ones, line low.
// - After reset enter sleep and accept commands over SPI.
// - The host's first status read after reset releases the line high.
// - The analog regulator runs only with RF active or in sleep-ADC.
// - Power down and the sleep modes enable units per the mode table.
// - Transmit and receive modes enable units per the mode table.
// - In sleep and sleep-ADC the crystal runs in high or low precision.
module pmrs_sequencer
    import pmrs_pkg::*;
#(
    parameter int unsigned RESET_CNT = RESET_CYCLES,
    parameter int unsigned PULSE_CNT = PULSE_CYCLES
) (
    input  wire logic                               core_clk,
    input  wire logic                               rst_n,
    input  wire logic                               power_on_pin,
    input  wire logic                               brownout_det,
    input  wire logic                               functional_ok,
    input  wire pmrs_mode_e                         mode_req,
    input  wire logic                               crystal_oscillator_high_prec_req,
    input  wire logic                               status_rd,
    input  wire logic                               status_set_valid,
    input  wire logic [N_STATUS-1:0][STATUS_W-1:0] status_set,
    output logic                                    irq_out_low_active,
    output logic                                    in_reset,
    output logic                                    spi_ready,
    output pmrs_mode_e                              mode_cur,
    output pmrs_enables_s                           enables,
    output logic [N_STATUS-1:0][STATUS_W-1:0]      status_regs
);
    import pmrs_pkg::*;

    localparam int unsigned CW = 32;

    typedef enum logic [2:0] {
        PMRS_ST_PDOWN,
        PMRS_ST_BROWN,
        PMRS_ST_PULSE,
        PMRS_ST_HOLD,
        PMRS_ST_RUN
    } pmrs_state_e;

    // Three-stage synchronisers; stage one feeds only stage two.
    logic [2:0] pon_sync_q;
    logic [2:0] bo_sync_q;
    logic [2:0] fok_sync_q;
    logic       pon_q;
    logic       bo_q;
    logic       fok_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pon_sync_q <= 3'h0;
            bo_sync_q  <= 3'h0;
            fok_sync_q <= 3'h0;
            pon_q      <= 1'b0;
            bo_q       <= 1'b0;
            fok_q      <= 1'b0;
        end else begin
            pon_sync_q <= {pon_sync_q[1:0], power_on_pin};
            bo_sync_q  <= {bo_sync_q[1:0], brownout_det};
            fok_sync_q <= {fok_sync_q[1:0], functional_ok};
            // A level counts only once stages two and three agree.
            if (pon_sync_q[1] == pon_sync_q[2]) begin
                pon_q <= pon_sync_q[2];
            end
            if (bo_sync_q[1] == bo_sync_q[2]) begin
                bo_q <= bo_sync_q[2];
            end
            if (fok_sync_q[1] == fok_sync_q[2]) begin
                fok_q <= fok_sync_q[2];
            end
        end
    end

    pmrs_state_e                        state_q, state_d;
    logic [CW-1:0]                      cnt_q, cnt_d;
    logic                               irq_n_q, irq_n_d;
    logic                               pend_q, pend_d;
    logic [N_STATUS-1:0][STATUS_W-1:0] stat_q, stat_d;
    pmrs_mode_e                         mode_q, mode_d;

    // Unit enables for a mode; the analog regulator follows RF activity and sleep-ADC.
    function automatic pmrs_enables_s mode_enables(input pmrs_mode_e m,
                                                    input logic hp);
        pmrs_enables_s e;
        e = ENABLES_OFF;
        e.dig_vreg             = 1'b1;
        e.config_register_file = 1'b1;
        case (m)
            PMRS_MODE_DEEP_SLEEP: begin
            end
            PMRS_MODE_SLEEP: begin
                e.crystal_oscillator = 1'b1;
                e.spi                = 1'b1;
                e.crystal_oscillator_high_prec     = hp;
            end
            PMRS_MODE_SLEEP_ADC: begin
                e.crystal_oscillator = 1'b1;
                e.spi                = 1'b1;
                e.ana_vreg           = 1'b1;
                e.crystal_oscillator_high_prec     = hp;
            end
            PMRS_MODE_TX_IDLE: begin
                e.crystal_oscillator = 1'b1;
                e.spi                = 1'b1;
                e.ana_vreg           = 1'b1;
                e.crystal_oscillator_high_prec     = 1'b1;
            end
            PMRS_MODE_TX_READY: begin
                e.crystal_oscillator = 1'b1;
                e.spi                = 1'b1;
                e.ana_vreg           = 1'b1;
                e.crystal_oscillator_high_prec     = 1'b1;
                e.pll                = 1'b1;
            end
            PMRS_MODE_TX: begin
                e.crystal_oscillator = 1'b1;
                e.spi                = 1'b1;
                e.ana_vreg           = 1'b1;
                e.crystal_oscillator_high_prec     = 1'b1;
                e.pll                = 1'b1;
                e.pa                 = 1'b1;
            end
            PMRS_MODE_RX: begin
                e.crystal_oscillator = 1'b1;
                e.spi                = 1'b1;
                e.ana_vreg           = 1'b1;
                e.crystal_oscillator_high_prec     = 1'b1;
                e.pll                = 1'b1;
                e.rx                 = 1'b1;
            end
            default: begin
                e = ENABLES_OFF;
            end
        endcase
        return e;
    endfunction : mode_enables

    // Sequencer next state. Power loss and brownout override any state.
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        irq_n_d = irq_n_q;
        pend_d  = pend_q;
        stat_d  = stat_q;
        mode_d  = mode_q;
        if (!pon_q) begin
            state_d = PMRS_ST_PDOWN;
            irq_n_d = 1'b0;
            pend_d  = 1'b0;
            stat_d  = '0;
            mode_d  = PMRS_MODE_SLEEP;
        end else if (bo_q) begin
            // Supply below brownout; line low while still functional.
            state_d = PMRS_ST_BROWN;
            irq_n_d = 1'b0;
            pend_d  = 1'b0;
            stat_d  = '0;
            mode_d  = PMRS_MODE_SLEEP;
        end else begin
            case (state_q)
                PMRS_ST_PDOWN: begin
                    // Rising power-on: regulators on, hold reset.
                    state_d = PMRS_ST_HOLD;
                    cnt_d   = CW'(RESET_CNT - 1);
                    irq_n_d = 1'b0;
                end
                PMRS_ST_BROWN: begin
                    // Supply back: high pulse, then full reset time.
                    state_d = PMRS_ST_PULSE;
                    cnt_d   = CW'(PULSE_CNT - 1);
                    irq_n_d = 1'b1;
                end
                PMRS_ST_PULSE: begin
                    if (cnt_q == '0) begin
                        state_d = PMRS_ST_HOLD;
                        cnt_d   = CW'(RESET_CNT - 1);
                        irq_n_d = 1'b0;
                    end else begin
                        cnt_d = cnt_q - 1'b1;
                    end
                end
                PMRS_ST_HOLD: begin
                    if (cnt_q == '0) begin
                        // Shared exit for power-on and brownout resets.
                        state_d = PMRS_ST_RUN;
                        stat_d  = {N_STATUS{STATUS_PRESET}};
                        irq_n_d = 1'b0;
                        pend_d  = 1'b1;
                        mode_d  = PMRS_MODE_SLEEP;
                    end else begin
                        cnt_d = cnt_q - 1'b1;
                    end
                end
                PMRS_ST_RUN: begin
                    mode_d = mode_req;
                    // New events set bits; a set in a read cycle wins.
                    if (status_rd) begin
                        stat_d = '0;
                    end
                    if (status_set_valid) begin
                        stat_d = stat_d | status_set;
                    end
                    if (status_rd && pend_q) begin
                        irq_n_d = 1'b1;
                        pend_d  = 1'b0;
                    end else if (!pend_q) begin
                        irq_n_d = !((stat_q | status_set) != '0 &&
                                    status_set_valid);
                        if (!status_set_valid) begin
                            irq_n_d = irq_n_q | status_rd;
                        end
                    end
                end
                default: begin
                    state_d = PMRS_ST_PDOWN;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= PMRS_ST_PDOWN;
            cnt_q   <= '0;
            irq_n_q <= 1'b0;
            pend_q  <= 1'b0;
            stat_q  <= '0;
            mode_q  <= PMRS_MODE_SLEEP;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            irq_n_q <= irq_n_d;
            pend_q  <= pend_d;
            stat_q  <= stat_d;
            mode_q  <= mode_d;
        end
    end

    // Enables follow the state; in brownout, pulse and hold only the digital rail runs, in power down none.
    always_comb begin
        enables = ENABLES_OFF;
        if (state_q == PMRS_ST_RUN) begin
            enables = mode_enables(mode_q, crystal_oscillator_high_prec_req);
        end else if (state_q != PMRS_ST_PDOWN) begin
            enables.dig_vreg = 1'b1;
        end
    end

    assign irq_out_low_active = irq_n_q;
    assign in_reset           = (state_q != PMRS_ST_RUN);
    assign spi_ready          = (state_q == PMRS_ST_RUN) && enables.spi;
    assign mode_cur           = mode_q;
    assign status_regs        = stat_q;

    AST_PDOWN_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_q == PMRS_ST_PDOWN |-> enables == ENABLES_OFF)
        else $error("Units powered in power down.");
    AST_PON_START: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_q == PMRS_ST_PDOWN && pon_q && !bo_q
        |=> state_q == PMRS_ST_HOLD && enables.dig_vreg)
        else $error("Power-on did not start reset.");
    AST_BO_RESET: assert property (@(posedge core_clk) disable iff (!rst_n)
        pon_q && bo_q |=> state_q == PMRS_ST_BROWN)
        else $error("Brownout did not reset.");
    AST_BO_IRQ_LOW: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_q == PMRS_ST_BROWN && $past(state_q) == PMRS_ST_BROWN
        |-> !irq_out_low_active)
        else $error("Interrupt line high during brownout.");
    AST_BO_PULSE: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_q == PMRS_ST_BROWN && pon_q && !bo_q
        |=> irq_out_low_active && state_q == PMRS_ST_PULSE)
        else $error("No recovery pulse.");
    AST_EXIT_PRESET: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(state_q == PMRS_ST_RUN)
        |-> stat_q == {N_STATUS{STATUS_PRESET}} && !irq_out_low_active)
        else $error("Status not preset at reset exit.");
    AST_EXIT_SLEEP: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(state_q == PMRS_ST_RUN)
        |-> mode_q == PMRS_MODE_SLEEP && spi_ready)
        else $error("Reset exit not in sleep.");
    AST_FIRST_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_q == PMRS_ST_RUN && pend_q && status_rd && pon_q && !bo_q
        |=> irq_out_low_active)
        else $error("First read did not release line.");
    AST_ANA_VREG: assert property (@(posedge core_clk) disable iff (!rst_n)
        enables.ana_vreg |-> state_q == PMRS_ST_RUN &&
        (enables.crystal_oscillator && mode_q >= PMRS_MODE_SLEEP_ADC))
        else $error("Analog regulator on outside RF modes.");
    AST_DEEP_SLEEP: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_q == PMRS_ST_RUN && mode_q == PMRS_MODE_DEEP_SLEEP
        |-> !enables.spi && !enables.crystal_oscillator)
        else $error("Deep sleep enables wrong.");
    AST_TX_PA: assert property (@(posedge core_clk) disable iff (!rst_n)
        enables.pa |-> enables.pll && !enables.rx)
        else $error("Amplifier enabled without PLL or with RX.");
    AST_HOLD_LEN: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(state_q == PMRS_ST_HOLD) |-> cnt_q == CW'(RESET_CNT - 1))
        else $error("Reset hold count wrong.");

    COV_PON: cover property (@(posedge core_clk) disable iff (!rst_n)
        $rose(state_q == PMRS_ST_RUN));
    COV_BO: cover property (@(posedge core_clk) disable iff (!rst_n)
        state_q == PMRS_ST_PULSE);
    COV_READ: cover property (@(posedge core_clk) disable iff (!rst_n)
        pend_q && status_rd);
    COV_TX: cover property (@(posedge core_clk) disable iff (!rst_n)
        enables.pa);

endmodule : pmrs_sequencer

// >>> rtl/pmrs_pkg.sv
// Package for the power mode and reset sequencer.
// Assumes a single 40 MHz core clock and a host that reads status over SPI.
package pmrs_pkg;

    // Core clock period in picoseconds.
    localparam int unsigned CLK_PERIOD_PS = 25000;
    // Reset hold time after the supply is good, in microseconds.
    localparam int unsigned RESET_TIME_US = 100;
    // Cycles of reset hold, rounded up to whole cycles.
    localparam int unsigned RESET_CYCLES =
        (RESET_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Width of the high pulse on the interrupt line after a brownout.
    localparam int unsigned PULSE_TIME_NS = 1000;
    localparam int unsigned PULSE_CYCLES =
        (PULSE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Number of interrupt status registers and their width.
    localparam int unsigned N_STATUS = 2;
    localparam int unsigned STATUS_W = 8;
    // Value loaded into every status register at reset exit.
    localparam logic [7:0] STATUS_PRESET = 8'hFF;
    localparam logic [7:0] STATUS_CLEAR  = 8'h00;

    // Operating modes requested by the host.
    typedef enum logic [2:0] {
        PMRS_MODE_DEEP_SLEEP,
        PMRS_MODE_SLEEP,
        PMRS_MODE_SLEEP_ADC,
        PMRS_MODE_TX_IDLE,
        PMRS_MODE_TX_READY,
        PMRS_MODE_TX,
        PMRS_MODE_RX
    } pmrs_mode_e;

    // Unit enables driven to the rest of the chip.
    typedef struct packed {
        logic dig_vreg;
        logic ana_vreg;
        logic crystal_oscillator;
        logic crystal_oscillator_high_prec;
        logic config_register_file;
        logic spi;
        logic pll;
        logic pa;
        logic rx;
    } pmrs_enables_s;

    localparam pmrs_enables_s ENABLES_OFF = '0;

endpackage : pmrs_pkg

// >>> tb/pmrs_host.sv
// Host model: drives the power-on pin and reads status after an interrupt.
// Assumes the sequencer samples its inputs on the rising core_clk edge.
module pmrs_host (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       irq_out_low_active,
    input  wire logic       in_reset,
    input  wire logic       pon_cmd,
    input  wire logic       auto_rd,
    input  wire logic [3:0] rd_delay,
    output logic            power_on_pin,
    output logic            status_rd
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [3:0] wait_q;

    // The pin follows the command at the falling edge, away from sampling.
    always @(negedge core_clk) begin
        power_on_pin <= pon_cmd;
    end

    // One read per low interrupt after a settable delay, so both a prompt
    // and a slow host can be shown; a pulse is never repeated back to back.
    always @(negedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_rd <= 1'b0;
            wait_q    <= 4'h0;
        end else begin
            status_rd <= 1'b0;
            wait_q    <= 4'h0;
            if (auto_rd && !irq_out_low_active && !in_reset &&
                !status_rd) begin
                if (wait_q == rd_delay) begin
                    status_rd <= 1'b1;
                end else begin
                    wait_q <= wait_q + 4'h1;
                end
            end
        end
    end
endmodule : pmrs_host

// >>> tb/power_mode_reset_sequencer_tb.sv
// Self-checking bench for the power mode and reset sequencer.
// Assumes the host model in pmrs_host and short reset and pulse counts.
module power_mode_reset_sequencer_tb
    import pmrs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned RST_C = 8;
    localparam int unsigned PUL_C = 2;

    logic                               core_clk = 1'b0;
    logic                               rst_n, power_on_pin, brownout_det;
    logic                               functional_ok, crystal_oscillator_high_prec_req;
    logic                               status_rd, status_set_valid;
    logic [N_STATUS-1:0][STATUS_W-1:0] status_set, status_regs;
    logic                               irq_out_low_active, in_reset;
    logic                               spi_ready, pon_cmd, auto_rd;
    logic [3:0]                         rd_delay;
    pmrs_mode_e                         mode_req, mode_cur;
    pmrs_enables_s                      enables;
    int                                 n_mismatch = 0;
    int                                 tests_run = 0;

    // Half period of 12.5 ns gives the 40 MHz core clock.
    always #12.5 core_clk = ~core_clk;

    pmrs_sequencer #(.RESET_CNT(RST_C), .PULSE_CNT(PUL_C)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .power_on_pin(power_on_pin),
        .brownout_det(brownout_det), .functional_ok(functional_ok),
        .mode_req(mode_req), .crystal_oscillator_high_prec_req(crystal_oscillator_high_prec_req),
        .status_rd(status_rd), .status_set_valid(status_set_valid),
        .status_set(status_set), .irq_out_low_active(irq_out_low_active),
        .in_reset(in_reset), .spi_ready(spi_ready), .mode_cur(mode_cur),
        .enables(enables), .status_regs(status_regs));

    pmrs_host host (
        .core_clk(core_clk), .rst_n(rst_n),
        .irq_out_low_active(irq_out_low_active), .in_reset(in_reset),
        .pon_cmd(pon_cmd), .auto_rd(auto_rd), .rd_delay(rd_delay),
        .power_on_pin(power_on_pin), .status_rd(status_rd));

    // Compare one value and count it; an unknown bit matches only an unknown bit in exp.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Bounded wait for the reset flag to reach a level, then check it.
    task automatic wait_rst(input logic lvl);
        for (int i = 0; i < 200 && in_reset !== lvl; i++) @(negedge core_clk);
        chk({15'h0, in_reset}, {15'h0, lvl});
    endtask : wait_rst

    // State expected in the first cycle after any reset ends.
    task automatic t_exit;
        chk(status_regs, 16'hFFFF);
        chk({15'h0, irq_out_low_active}, 16'h0);
        chk({13'h0, mode_cur}, {13'h0, PMRS_MODE_SLEEP});
        chk({15'h0, spi_ready}, 16'h1);
    endtask : t_exit

    task automatic t_power_down;
        pon_cmd = 1'b0;
        wait_rst(1'b1);
        repeat (3) @(negedge core_clk);
        chk({7'h0, enables}, 16'h0);
        $display("test power_down done");
    endtask : t_power_down

    // Power-up, exit sequence, then a slow host read releases the line.
    task automatic t_power_up;
        pon_cmd = 1'b1;
        for (int i = 0; i < 10 && enables.dig_vreg !== 1'b1; i++)
            @(negedge core_clk);
        chk({enables.dig_vreg, in_reset}, 2'b11);
        wait_rst(1'b0);
        t_exit();
        repeat (4) @(negedge core_clk);
        chk({15'h0, irq_out_low_active}, 16'h0);
        rd_delay = 4'h3;
        auto_rd = 1'b1;
        for (int i = 0; i < 10 && irq_out_low_active !== 1'b1; i++)
            @(negedge core_clk);
        chk({15'h0, irq_out_low_active}, 16'h1);
        auto_rd = 1'b0;
        $display("test power_up done");
    endtask : t_power_up

    // Every requested mode with both crystal precision requests.
    task automatic t_modes;
        logic [8:0] e;
        for (int m = 0; m < 7; m++) begin
            for (int h = 0; h < 2; h++) begin
                mode_req = pmrs_mode_e'(m);
                crystal_oscillator_high_prec_req = h[0];
                repeat (3) @(negedge core_clk);
                case (m)
                    0: e = 9'h110;
                    1: e = 9'h158;
                    2: e = 9'h1D8;
                    3: e = 9'h1F8;
                    4: e = 9'h1FC;
                    5: e = 9'h1FE;
                    default: e = 9'h1FD;
                endcase
                if (m == 1 || m == 2) e[5] = h[0];
                chk({13'h0, mode_cur}, 16'(m));
                chk({7'h0, enables}, {7'h0, e});
                chk({15'h0, spi_ready}, {15'h0, e[3]});
            end
        end
        mode_req = PMRS_MODE_SLEEP;
        $display("test modes done");
    endtask : t_modes

    // A new status event pulls the line low; a prompt read releases it.
    task automatic t_status_set;
        status_set = 16'h0081;
        status_set_valid = 1'b1;
        @(negedge core_clk);
        status_set_valid = 1'b0;
        @(negedge core_clk);
        chk({status_regs[0], 7'h0, irq_out_low_active}, 16'h8100);
        rd_delay = 4'h0;
        auto_rd = 1'b1;
        repeat (4) @(negedge core_clk);
        chk({15'h0, irq_out_low_active}, 16'h1);
        auto_rd = 1'b0;
        $display("test status_set done");
    endtask : t_status_set

    // Brownout in mid-run: low line, high pulse, full hold, exit sequence.
    task automatic t_brownout;
        int n;
        brownout_det = 1'b1;
        wait_rst(1'b1);
        repeat (5) @(negedge core_clk);
        chk({15'h0, irq_out_low_active}, 16'h0);
        brownout_det = 1'b0;
        for (int i = 0; i < 10 && irq_out_low_active !== 1'b1; i++)
            @(negedge core_clk);
        n = 0;
        while (n < 50 && irq_out_low_active === 1'b1) begin
            n++;
            @(negedge core_clk);
        end
        chk(16'(n), 16'(PUL_C));
        n = 0;
        while (n < 100 && in_reset === 1'b1) begin
            n++;
            @(negedge core_clk);
        end
        chk(16'(n), 16'(RST_C));
        t_exit();
        $display("test brownout done");
    endtask : t_brownout

    // Single place where the run ends.
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude

    // Watchdog sized well above the fewer than two hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        $display("Watchdog expired at %0t", $time);
        conclude();
    end

    // Main sequence; inputs move on the falling edge only.
    initial begin
        rst_n = 1'b0;
        brownout_det = 1'b0;
        functional_ok = 1'b1;
        mode_req = PMRS_MODE_SLEEP;
        crystal_oscillator_high_prec_req = 1'b0;
        status_set_valid = 1'b0;
        status_set = 16'h0000;
        pon_cmd = 1'b0;
        auto_rd = 1'b0;
        rd_delay = 4'h0;
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        t_power_down();
        t_power_up();
        t_modes();
        t_status_set();
        t_brownout();
        t_power_down();
        t_power_up();
        conclude();
    end
endmodule : power_mode_reset_sequencer_tb
